//--- verilog/upcr_cfg.svh
// Constants for the peripheral configuration register set
//
// Contract
// - Request output polarity follows config bit 6
// - Acknowledge input polarity follows config bit 5
// - End-of-transfer polarity follows config bit 4
// - Chip select low wakes, only with bus power
// - Power-off bit makes suspend output switch control
// - Firmware initialises power-off bit to one
// - Config bit 1 selects level or 166 ns pulse; the pulse here lasts 21 clocks of 8 ns, 168 ns
// - Interrupt output polarity follows config bit 0
// - Bus reset keeps enables and config bits
// - Enable map written C2, read C3, four bytes
// - Software writes zero to enable bits 31..24
// - Bits 23..10 enable endpoints 14..1
// - Bit 9 control IN, bit 8 control OUT
// - Bit 6 enables short packet interrupt
// - Bit 5 enables pseudo frame interrupt
// - Bit 4 frame start, bit 3 transfer end
// - Bits 2,1,0 suspend, resume, bus reset
// - DMA config written F0, read F1, two bytes
// - Bus reset clears DMA enable only
// - DMA enable bit starts, stops, reports DMA
// - Burst field selects 1, 4, 8, 16 bytes
// - Bit 15 ends transfer at counter zero
// - Bit 14 ends transfer on short packet
`ifndef UPCR_CFG_SVH
`define UPCR_CFG_SVH
`define UPCR_CMD_WR_HWCFG 8'hba
`define UPCR_CMD_RD_HWCFG 8'hbb
`define UPCR_CMD_WR_IEN 8'hc2
`define UPCR_CMD_RD_IEN 8'hc3
`define UPCR_CMD_WR_DMACFG 8'hf0
`define UPCR_CMD_RD_DMACFG 8'hf1
`define UPCR_HWCFG_RESET 16'h2340
`define UPCR_IEN_RESET 32'h00000000
`define UPCR_DMACFG_RESET 16'h0000
`define UPCR_IEN_RSVD_MASK 32'h00ffff7f
`define UPCR_DMACFG_MASK 16'hc0fb
`define UPCR_HW_DMA_REQUEST_POLARITY_BIT 6
`define UPCR_HW_DMA_ACK_POLARITY_BIT 5
`define UPCR_HW_END_OF_TRANSFER_POLARITY_BIT 4
`define UPCR_HW_WAKE_BIT 3
`define UPCR_HW_SUSPEND_POWER_OFF_ENABLE_BIT 2
`define UPCR_HW_PULSE_BIT 1
`define UPCR_HW_IRQPOL_BIT 0
`define UPCR_DMA_EN_BIT 3
`define UPCR_DMA_CNTR_BIT 15
`define UPCR_DMA_SHORT_BIT 14
`define UPCR_PULSE_NS 166
`define UPCR_CLK_NS 8
`define UPCR_PULSE_CYC ((`UPCR_PULSE_NS + `UPCR_CLK_NS - 1) / `UPCR_CLK_NS)
`define UPCR_APB_CMD 12'h000
`define UPCR_APB_WDATA 12'h004
`define UPCR_APB_RDATA 12'h008
`define UPCR_APB_STATUS 12'h00c
`define UPCR_APB_IEN_BYTES 3'd4
`define UPCR_APB_HALF_BYTES 3'd2
`endif

//--- verilog/upcr_pkg.sv
// Types shared by both ends of the configuration link
package upcr_pkg;
    typedef enum logic [1:0] {
        UPCR_IDLE = 2'b00,
        UPCR_CMD = 2'b01,
        UPCR_DATA = 2'b11
    } upcr_link_t;
endpackage

//--- verilog/upcr_if.sv
// Command link between the system controller and the register set
`timescale 1ns/1ns
interface upcr_if;
    logic cmd_valid;
    logic [7:0] cmd_code;
    logic wr_valid;
    logic [7:0] wr_byte;
    logic rd_req;
    logic [7:0] rd_byte;
    logic rd_valid;
    modport dev (
        input cmd_valid, cmd_code, wr_valid, wr_byte, rd_req,
        output rd_byte, rd_valid
    );
    modport host (
        output cmd_valid, cmd_code, wr_valid, wr_byte, rd_req,
        input rd_byte, rd_valid
    );
endinterface

//--- verilog/upcr_sync.sv
// Two-stage synchroniser for pin levels
`timescale 1ns/1ns
module upcr_sync #(
    parameter int WIDTH = 1
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] meta_q;
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            meta_q <= '0;
            dout <= '0;
        end else begin
            meta_q <= din;
            dout <= meta_q;
        end
    end
endmodule

//--- verilog/upcr_device.sv
// Configuration, interrupt enable and DMA configuration registers
//
// The register addresses and register access over APB were decided locally.
`timescale 1ns/1ns
`include "upcr_cfg.svh"
module upcr_device
    import upcr_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    upcr_if.dev link,
    input wire logic bus_reset,
    input wire logic [23:0] irq_events,
    input wire logic dma_ack_pin,
    input wire logic chip_select_n_pin,
    input wire logic vbus_pin,
    input wire logic suspended,
    input wire logic dma_want,
    input wire logic dma_counter_zero,
    input wire logic short_packet_rx,
    output logic dma_request_pin,
    output logic end_of_transfer_pin,
    output logic irq_pin,
    output logic suspend_pin,
    output logic remote_wake,
    output logic dma_active,
    output logic [1:0] dma_burst_code,
    output logic [3:0] dma_endpoint_select
);
    typedef struct packed {
        logic [7:0] cmd;
        logic [1:0] idx;
        logic [15:0] hw_config_low;
        logic [31:0] interrupt_enable_map;
        logic [15:0] dma_configuration;
        logic [31:0] shift;
        logic [7:0] rd_byte;
        logic rd_valid;
        logic irq_level;
        logic [7:0] pulse_cnt;
        logic drq;
        logic end_of_transfer;
        logic irq;
        logic susp;
        logic wake;
        logic dma_act;
    } upcr_dev_t;

    upcr_dev_t s_q;
    upcr_dev_t s_d;
    logic [2:0] pin_s;
    logic ack_on;
    logic irq_hit;
    logic end_cond;

    upcr_sync #(.WIDTH(3)) u_sync (
        .ref_clk(ref_clk),
        .rst(rst),
        .din({dma_ack_pin, chip_select_n_pin, vbus_pin}),
        .dout(pin_s)
    );

    // ------------------------------
    // Register access and pins
    // ------------------------------
    always_comb begin
        s_d = s_q;
        s_d.rd_valid = 1'b0;
        if (link.cmd_valid) begin
            s_d.cmd = link.cmd_code;
            s_d.idx = 2'd0;
            case (link.cmd_code)
                `UPCR_CMD_RD_IEN: s_d.shift = s_q.interrupt_enable_map;
                `UPCR_CMD_RD_DMACFG: s_d.shift = {16'h0000, s_q.dma_configuration};
                `UPCR_CMD_RD_HWCFG: s_d.shift = {16'h0000, s_q.hw_config_low};
                default: s_d.shift = 32'h00000000;
            endcase
        end else if (link.wr_valid) begin
            s_d.idx = s_q.idx + 2'd1;
            case (s_q.cmd)
                `UPCR_CMD_WR_IEN: s_d.interrupt_enable_map[s_q.idx*8 +: 8] = link.wr_byte;
                `UPCR_CMD_WR_DMACFG: begin
                    if (!s_q.idx[1]) begin
                        s_d.dma_configuration[s_q.idx[0]*8 +: 8] = link.wr_byte;
                    end
                end
                `UPCR_CMD_WR_HWCFG: begin
                    if (!s_q.idx[1]) begin
                        s_d.hw_config_low[s_q.idx[0]*8 +: 8] = link.wr_byte;
                    end
                end
                default: ;
            endcase
        end else if (link.rd_req) begin
            s_d.rd_byte = s_q.shift[7:0];
            s_d.shift = {8'h00, s_q.shift[31:8]};
            s_d.rd_valid = 1'b1;
        end
        s_d.dma_configuration = s_d.dma_configuration & `UPCR_DMACFG_MASK;
        if (bus_reset) begin
            s_d.dma_configuration[`UPCR_DMA_EN_BIT] = 1'b0;
        end
        ack_on = pin_s[2] == s_q.hw_config_low[`UPCR_HW_DMA_ACK_POLARITY_BIT];
        end_cond = (s_q.dma_configuration[`UPCR_DMA_CNTR_BIT] && dma_counter_zero)
            || (s_q.dma_configuration[`UPCR_DMA_SHORT_BIT] && short_packet_rx);
        s_d.dma_act = s_q.dma_configuration[`UPCR_DMA_EN_BIT];
        s_d.drq = (s_q.dma_act && dma_want && !ack_on)
            ~^ s_q.hw_config_low[`UPCR_HW_DMA_REQUEST_POLARITY_BIT];
        s_d.end_of_transfer = (s_q.dma_act && ack_on && end_cond)
            ~^ s_q.hw_config_low[`UPCR_HW_END_OF_TRANSFER_POLARITY_BIT];
        s_d.wake = s_q.hw_config_low[`UPCR_HW_WAKE_BIT] && !pin_s[1] && pin_s[0];
        s_d.susp = s_q.hw_config_low[`UPCR_HW_SUSPEND_POWER_OFF_ENABLE_BIT] && suspended;
        irq_hit = |(irq_events & s_q.interrupt_enable_map[23:0]
            & 24'(`UPCR_IEN_RSVD_MASK));
        s_d.irq_level = irq_hit;
        if (irq_hit && !s_q.irq_level) begin
            s_d.pulse_cnt = 8'(`UPCR_PULSE_CYC);
        end else if (s_q.pulse_cnt != 8'h00) begin
            s_d.pulse_cnt = s_q.pulse_cnt - 8'h01;
        end
        s_d.irq = (s_q.hw_config_low[`UPCR_HW_PULSE_BIT] ? (s_q.pulse_cnt != 8'h00) : irq_hit)
            ~^ s_q.hw_config_low[`UPCR_HW_IRQPOL_BIT];
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s_q <= '0;
            s_q.hw_config_low <= `UPCR_HWCFG_RESET;
            s_q.drq <= 1'b0;
            s_q.end_of_transfer <= 1'b0;
            s_q.irq <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    assign link.rd_byte = s_q.rd_byte;
    assign link.rd_valid = s_q.rd_valid;
    assign dma_request_pin = s_q.drq;
    assign end_of_transfer_pin = s_q.end_of_transfer;
    assign irq_pin = s_q.irq;
    assign suspend_pin = s_q.susp;
    assign remote_wake = s_q.wake;
    assign dma_active = s_q.dma_act;
    assign dma_burst_code = s_q.dma_configuration[1:0];
    assign dma_endpoint_select = s_q.dma_configuration[7:4];
endmodule

//--- verilog/upcr_host.sv
// System controller end: APB command registers drive the link
`timescale 1ns/1ns
`include "upcr_cfg.svh"
module upcr_host
    import upcr_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    upcr_if.host link
);
    typedef struct packed {
        upcr_link_t st;
        logic [7:0] cmd;
        logic [31:0] wdata;
        logic [31:0] rdata;
        logic [2:0] cnt;
        logic [2:0] nbytes;
        logic [1:0] ridx;
        logic wr;
        logic busy;
        logic cmd_valid;
        logic wr_valid;
        logic rd_req;
        logic [7:0] wr_byte;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } upcr_host_t;

    upcr_host_t h_q;
    upcr_host_t h_d;
    logic acc;

    always_comb begin
        h_d = h_q;
        h_d.cmd_valid = 1'b0;
        h_d.wr_valid = 1'b0;
        h_d.rd_req = 1'b0;
        h_d.pready = 1'b0;
        h_d.pslverr = 1'b0;
        acc = psel && penable && !h_q.pready;
        if (acc) begin
            h_d.pready = 1'b1;
            h_d.prdata = 32'h00000000;
            case (paddr)
                `UPCR_APB_CMD: begin
                    if (pwrite && !h_q.busy) begin
                        h_d.cmd = pwdata[7:0];
                        h_d.st = UPCR_CMD;
                        h_d.busy = 1'b1;
                    end else begin
                        h_d.prdata = {24'h000000, h_q.cmd};
                    end
                end
                `UPCR_APB_WDATA: begin
                    if (pwrite) h_d.wdata = pwdata;
                    else h_d.prdata = h_q.wdata;
                end
                `UPCR_APB_RDATA: h_d.prdata = h_q.rdata;
                `UPCR_APB_STATUS: h_d.prdata = {31'h00000000, h_q.busy};
                default: h_d.pslverr = 1'b1;
            endcase
        end
        if (link.rd_valid) begin
            h_d.rdata[h_q.ridx*8 +: 8] = link.rd_byte;
            h_d.ridx = h_q.ridx + 2'd1;
        end
        case (h_q.st)
            UPCR_CMD: begin
                h_d.cmd_valid = 1'b1;
                h_d.cnt = 3'd0;
                h_d.ridx = 2'd0;
                h_d.rdata = 32'h00000000;
                h_d.wr = !h_q.cmd[0];
                h_d.nbytes = (h_q.cmd == `UPCR_CMD_WR_IEN || h_q.cmd == `UPCR_CMD_RD_IEN)
                    ? `UPCR_APB_IEN_BYTES : `UPCR_APB_HALF_BYTES;
                h_d.st = UPCR_DATA;
            end
            UPCR_DATA: begin
                if (h_q.cnt == h_q.nbytes) begin
                    if (h_q.wr || !h_q.rd_req) begin
                        h_d.st = UPCR_IDLE;
                        h_d.busy = 1'b0;
                    end
                end else begin
                    h_d.wr_valid = h_q.wr;
                    h_d.rd_req = !h_q.wr;
                    h_d.wr_byte = h_q.wdata[h_q.cnt*8 +: 8];
                    h_d.cnt = h_q.cnt + 3'd1;
                end
            end
            default: ;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            h_q <= '0;
        end else begin
            h_q <= h_d;
        end
    end

    assign prdata = h_q.prdata;
    assign pready = h_q.pready;
    assign pslverr = h_q.pslverr;
    assign link.cmd_valid = h_q.cmd_valid;
    assign link.cmd_code = h_q.cmd;
    assign link.wr_valid = h_q.wr_valid;
    assign link.wr_byte = h_q.wr_byte;
    assign link.rd_req = h_q.rd_req;
endmodule

//--- bench/upcr_link_chk.sv
// Protocol checker for the configuration command link
`timescale 1ns/1ns
`include "upcr_cfg.svh"
module upcr_link_chk (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_code,
    input wire logic wr_valid,
    input wire logic [7:0] wr_byte,
    input wire logic rd_req,
    input wire logic [7:0] rd_byte,
    input wire logic rd_valid
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    property p_ien_wr;
        cmd_valid && cmd_code == `UPCR_CMD_WR_IEN |=> wr_valid [*4] ##1 !wr_valid;
    endproperty
    a_ien_wr: assert property (p_ien_wr) else $error("enable map write not 4 bytes");
    property p_ien_rd;
        cmd_valid && cmd_code == `UPCR_CMD_RD_IEN |=> rd_req [*4] ##1 !rd_req;
    endproperty
    a_ien_rd: assert property (p_ien_rd) else $error("enable map read not 4 bytes");
    property p_dma_wr;
        cmd_valid && cmd_code == `UPCR_CMD_WR_DMACFG |=> wr_valid [*2] ##1 !wr_valid;
    endproperty
    a_dma_wr: assert property (p_dma_wr) else $error("dma config write not 2 bytes");
    property p_dma_rd;
        cmd_valid && cmd_code == `UPCR_CMD_RD_DMACFG |=> rd_req [*2] ##1 !rd_req;
    endproperty
    a_dma_rd: assert property (p_dma_rd) else $error("dma config read not 2 bytes");
    property p_rd_ans; rd_req |=> rd_valid; endproperty
    a_rd_ans: assert property (p_rd_ans) else $error("read byte not answered");
    property p_rd_src; rd_valid |-> $past(rd_req); endproperty
    a_rd_src: assert property (p_rd_src) else $error("read byte without request");
    property p_excl; cmd_valid |-> !wr_valid && !rd_req; endproperty
    a_excl: assert property (p_excl) else $error("command overlaps data byte");
    property p_wr_start; $rose(wr_valid) |-> $past(cmd_valid); endproperty
    a_wr_start: assert property (p_wr_start) else $error("data byte without command");
    c_ien: cover property (cmd_valid && cmd_code == `UPCR_CMD_WR_IEN);
    c_dma: cover property (cmd_valid && cmd_code == `UPCR_CMD_WR_DMACFG);
    c_rd: cover property (rd_req ##1 rd_valid);
endmodule

//--- bench/upcr_tb.sv
// Self-checking bench for both ends of the configuration link
`timescale 1ns/1ns
`include "upcr_cfg.svh"
module usb_periph_cfg_irq_dma_regs_tb_top;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, serr;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rdat;
    logic bus_reset = 1'b0, dma_ack_pin = 1'b0, chip_select_n_pin = 1'b1, vbus_pin = 1'b0;
    logic suspended = 1'b0, dma_want = 1'b0, dma_counter_zero = 1'b0, short_packet_rx = 1'b0;
    logic [23:0] irq_events = 24'h0;
    logic dma_request_pin, end_of_transfer_pin, irq_pin, suspend_pin, remote_wake, dma_active;
    logic [1:0] dma_burst_code;
    logic [3:0] dma_endpoint_select;
    int err_total = 0, n_checks = 0, k;
    upcr_if link ();
    always #4 ref_clk = ~ref_clk;
    upcr_host u_upcr_host (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .link(link));
    upcr_device u_upcr_device (.ref_clk(ref_clk), .rst(rst), .link(link), .bus_reset(bus_reset),
        .irq_events(irq_events), .dma_ack_pin(dma_ack_pin), .chip_select_n_pin(chip_select_n_pin),
        .vbus_pin(vbus_pin), .suspended(suspended), .dma_want(dma_want),
        .dma_counter_zero(dma_counter_zero), .short_packet_rx(short_packet_rx),
        .dma_request_pin(dma_request_pin), .end_of_transfer_pin(end_of_transfer_pin),
        .irq_pin(irq_pin), .suspend_pin(suspend_pin), .remote_wake(remote_wake),
        .dma_active(dma_active), .dma_burst_code(dma_burst_code),
        .dma_endpoint_select(dma_endpoint_select));
    upcr_link_chk u_upcr_link_chk (.ref_clk(ref_clk), .rst(rst), .cmd_valid(link.cmd_valid),
        .cmd_code(link.cmd_code), .wr_valid(link.wr_valid), .wr_byte(link.wr_byte),
        .rd_req(link.rd_req), .rd_byte(link.rd_byte), .rd_valid(link.rd_valid));
    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic hang();
        err_total++;
        $display("[FAIL] wait expected done seen timeout");
        test_done();
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        for (i = 0; i < 20 && pready !== 1'b1; i++) @(posedge ref_clk);
        if (i == 20) hang();
        rdat = prdata;
        serr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Load data, issue code, poll busy, fetch read data
    task automatic cmd(input logic [7:0] code, input logic [31:0] d);
        int i;
        apb(1'b1, `UPCR_APB_WDATA, d);
        apb(1'b1, `UPCR_APB_CMD, {24'h0, code});
        rdat = 32'h1;
        for (i = 0; i < 20 && rdat[0] !== 1'b0; i++) apb(1'b0, `UPCR_APB_STATUS, 32'h0);
        if (i == 20) hang();
        apb(1'b0, `UPCR_APB_RDATA, 32'h0);
    endtask
    initial begin
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (2) @(posedge ref_clk);
        chk("irq idle", irq_pin, 1'b1);
        chk("drq idle", dma_request_pin, 1'b0);
        chk("eot idle", end_of_transfer_pin, 1'b1);
        cmd(`UPCR_CMD_RD_HWCFG, 32'h0);
        chk("hwcfg reset", rdat[15:0], `UPCR_HWCFG_RESET);
        cmd(`UPCR_CMD_WR_HWCFG, 32'h0);
        chk("drq low idle", dma_request_pin, 1'b1);
        cmd(`UPCR_CMD_RD_IEN, 32'h0);
        chk("ien reset", rdat, `UPCR_IEN_RESET);
        cmd(`UPCR_CMD_RD_DMACFG, 32'h0);
        chk("dma reset", rdat[15:0], `UPCR_DMACFG_RESET);
        cmd(`UPCR_CMD_WR_IEN, 32'h00ffff7f);
        cmd(`UPCR_CMD_RD_IEN, 32'h0);
        chk("ien map", rdat, 32'h00ffff7f);
        apb(1'b0, 12'h010, 32'h0);
        chk("unmapped", serr, 1'b1);
        for (k = 0; k < 24; k++) if (k != 7) begin
            cmd(`UPCR_CMD_WR_IEN, 32'h1 << k);
            irq_events <= ~(24'h1 << k);
            repeat (4) @(posedge ref_clk);
            chk("irq masked", irq_pin, 1'b1);
            irq_events <= 24'h1 << k;
            repeat (4) @(posedge ref_clk);
            chk("irq enabled", irq_pin, 1'b0);
            irq_events <= 24'h0;
        end
        cmd(`UPCR_CMD_WR_HWCFG, 32'h7d);
        chk("irq high idle", irq_pin, 1'b0);
        chk("drq high idle", dma_request_pin, 1'b0);
        chk("eot high idle", end_of_transfer_pin, 1'b0);
        cmd(`UPCR_CMD_WR_HWCFG, 32'h7f);
        irq_events <= 24'h800000;
        for (k = 0; k < 10 && irq_pin !== 1'b1; k++) @(posedge ref_clk);
        for (k = 0; k < 40 && irq_pin === 1'b1; k++) @(posedge ref_clk);
        chk("pulse width", k, `UPCR_PULSE_CYC);
        irq_events <= 24'h0;
        chip_select_n_pin <= 1'b0;
        suspended <= 1'b1;
        repeat (5) @(posedge ref_clk);
        chk("wake no vbus", remote_wake, 1'b0);
        chk("suspend out", suspend_pin, 1'b1);
        vbus_pin <= 1'b1;
        repeat (5) @(posedge ref_clk);
        chk("wake", remote_wake, 1'b1);
        chip_select_n_pin <= 1'b1;
        suspended <= 1'b0;
        dma_want <= 1'b1;
        for (k = 0; k < 4; k++) begin
            cmd(`UPCR_CMD_WR_DMACFG, 32'hc0f8 | k);
            chk("burst", dma_burst_code, k[1:0]);
            chk("dma on", dma_active, 1'b1);
            chk("drq", dma_request_pin, 1'b1);
        end
        chk("endpoint", dma_endpoint_select, 4'hf);
        dma_ack_pin <= 1'b1;
        dma_counter_zero <= 1'b1;
        repeat (4) @(posedge ref_clk);
        chk("drq acked", dma_request_pin, 1'b0);
        chk("eot counter", end_of_transfer_pin, 1'b1);
        dma_counter_zero <= 1'b0;
        repeat (4) @(posedge ref_clk);
        chk("eot off", end_of_transfer_pin, 1'b0);
        short_packet_rx <= 1'b1;
        repeat (4) @(posedge ref_clk);
        chk("eot short", end_of_transfer_pin, 1'b1);
        short_packet_rx <= 1'b0;
        dma_ack_pin <= 1'b0;
        cmd(`UPCR_CMD_RD_DMACFG, 32'h0);
        chk("dma read", rdat[15:0], 16'hc0fb);
        bus_reset <= 1'b1;
        @(posedge ref_clk);
        bus_reset <= 1'b0;
        repeat (4) @(posedge ref_clk);
        chk("dma off", dma_active, 1'b0);
        cmd(`UPCR_CMD_RD_DMACFG, 32'h0);
        chk("dma after bus reset", rdat[15:0], 16'hc0f3);
        cmd(`UPCR_CMD_RD_IEN, 32'h0);
        chk("ien after bus reset", rdat, 32'h00800000);
        cmd(`UPCR_CMD_RD_HWCFG, 32'h0);
        chk("hwcfg after bus reset", rdat[15:0], 16'h007f);
        test_done();
    end
endmodule
